/* hdl/fwav_regs.vh */
// register map, field positions, reset values and codes of the fifo/waveform autovector block
`ifndef FWAV_REGS_VH
`define FWAV_REGS_VH

// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define FWAV_ADDR_W          8
`define FWAV_OFF_SETUP       8'h00
`define FWAV_OFF_STATUS      8'h04
`define FWAV_OFF_MASK        8'h08
`define FWAV_OFF_VECTOR      8'h0c
`define FWAV_OFF_RAW         8'h10

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define FWAV_SETUP_AVEN_BIT  0
`define FWAV_VECTOR_VALID_BIT 8
`define FWAV_NUM_SRC         14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FWAV_SETUP_RST       1'h0
`define FWAV_STATUS_RST      14'h0000
`define FWAV_MASK_RST        14'h0000

// ----------------------------------------------------------------
// vector codes and code memory locations
// ----------------------------------------------------------------
`define FWAV_VEC_BASE        8'h80
`define FWAV_VEC_STEP_SHIFT  2
`define FWAV_PAGE_ADDR       16'h0054
`define FWAV_VEC_ADDR        16'h0055
`define FWAV_ISR_ADDR        16'h0053

`endif

/* hdl/fwav_autovector.v */
// fifo/waveform shared interrupt with priority vectoring, apb registers and code byte substitution
//
// The placing of the registers and register access over APB were left to the implementer.
`include "fwav_regs.vh"

module fwav_autovector (
  input  wire        sys_clk,
  input  wire        reset,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // interrupt sources, levels
  input  wire        ep_two_level_flag,
  input  wire        ep_four_level_flag,
  input  wire        ep_six_level_flag,
  input  wire        ep_eight_level_flag,
  input  wire        ep_two_empty_flag,
  input  wire        ep_four_empty_flag,
  input  wire        ep_six_empty_flag,
  input  wire        ep_eight_empty_flag,
  input  wire        ep_two_full_flag,
  input  wire        ep_four_full_flag,
  input  wire        ep_six_full_flag,
  input  wire        ep_eight_full_flag,
  input  wire        waveform_engine_done,
  input  wire        waveform_engine_wave_event,
  // core side
  output wire        fifo_wave_shared_irq,
  input  wire        irq_taken,
  input  wire [15:0] return_pc,
  output reg         pc_push_valid,
  output reg  [15:0] pc_push_value,
  output reg         jump_valid,
  output reg  [15:0] jump_addr,
  // code fetch path
  input  wire        code_fetch,
  input  wire [15:0] code_addr,
  input  wire [7:0]  code_mem_byte,
  output reg         code_byte_valid,
  output reg  [7:0]  code_byte
);

  // ----------------------------------------------------------------
  // source gathering
  // ----------------------------------------------------------------
  wire [13:0] src_level;
  reg  [13:0] src_prev_q;
  wire [13:0] src_rise;

  // bit index is priority minus one
  assign src_level = {waveform_engine_wave_event,
                      waveform_engine_done,
                      ep_eight_full_flag,
                      ep_six_full_flag,
                      ep_four_full_flag,
                      ep_two_full_flag,
                      ep_eight_empty_flag,
                      ep_six_empty_flag,
                      ep_four_empty_flag,
                      ep_two_empty_flag,
                      ep_eight_level_flag,
                      ep_six_level_flag,
                      ep_four_level_flag,
                      ep_two_level_flag};

  always @(posedge sys_clk) begin
    if (reset) begin
      src_prev_q <= 14'h0000;
    end else begin
      src_prev_q <= src_level;
    end
  end

  assign src_rise = src_level & ~src_prev_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  reg         aven_q;
  reg  [13:0] status_q;
  reg  [13:0] mask_q;
  reg  [13:0] rd_snap_q;
  wire        setup_ph;
  wire        access_ph;
  wire [7:0]  word_addr;
  wire        hit_setup;
  wire        hit_status;
  wire        hit_mask;
  wire        hit_vector;
  wire        hit_raw;
  wire        hit_any;
  wire        wr_setup;
  wire        wr_mask;
  wire        rd_status;

  assign setup_ph   = psel & ~penable;
  assign access_ph  = psel & penable;
  assign word_addr  = {paddr[7:2], 2'h0};
  assign hit_setup  = (paddr[31:8] == 24'h000000) & (word_addr == `FWAV_OFF_SETUP);
  assign hit_status = (paddr[31:8] == 24'h000000) & (word_addr == `FWAV_OFF_STATUS);
  assign hit_mask   = (paddr[31:8] == 24'h000000) & (word_addr == `FWAV_OFF_MASK);
  assign hit_vector = (paddr[31:8] == 24'h000000) & (word_addr == `FWAV_OFF_VECTOR);
  assign hit_raw    = (paddr[31:8] == 24'h000000) & (word_addr == `FWAV_OFF_RAW);
  assign hit_any    = hit_setup | hit_status | hit_mask | hit_vector | hit_raw;

  assign pready     = 1'b1;
  assign pslverr    = access_ph & ~hit_any;

  assign wr_setup   = access_ph & pwrite & hit_setup;
  assign wr_mask    = access_ph & pwrite & hit_mask;
  assign rd_status  = access_ph & ~pwrite & hit_status;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      aven_q <= `FWAV_SETUP_RST;
    end else if (wr_setup) begin
      aven_q <= pwdata[`FWAV_SETUP_AVEN_BIT];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      mask_q <= `FWAV_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= pwdata[13:0];
    end
  end

  // ----------------------------------------------------------------
  // sticky status, read clears only the bits software saw
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `FWAV_NUM_SRC; gi = gi + 1) begin : g_status
      always @(posedge sys_clk) begin
        if (reset) begin
          status_q[gi] <= 1'b0;
        end else if (src_rise[gi]) begin
          status_q[gi] <= 1'b1;
        end else if (rd_status & rd_snap_q[gi]) begin
          status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // shared request and priority encode
  // ----------------------------------------------------------------
  wire [13:0] pending;
  reg  [3:0]  win_idx;
  reg         win_valid;
  wire [7:0]  win_code;
  integer     k;

  assign pending = status_q & mask_q;
  assign fifo_wave_shared_irq = |pending;

  always @* begin
    win_idx   = 4'h0;
    win_valid = 1'b0;
    for (k = `FWAV_NUM_SRC - 1; k >= 0; k = k - 1) begin
      if (pending[k]) begin
        win_idx   = k[3:0];
        win_valid = 1'b1;
      end
    end
  end

  // code = base + 4 * (priority - 1)
  assign win_code = `FWAV_VEC_BASE + {2'h0, win_idx, 2'h0};

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h00000000;
    if (hit_setup) begin
      rdata_d[`FWAV_SETUP_AVEN_BIT] = aven_q;
    end else if (hit_status) begin
      rdata_d[13:0] = status_q;
    end else if (hit_mask) begin
      rdata_d[13:0] = mask_q;
    end else if (hit_vector) begin
      rdata_d[7:0] = win_valid ? win_code : 8'h00;
      rdata_d[`FWAV_VECTOR_VALID_BIT] = win_valid;
    end else if (hit_raw) begin
      rdata_d[13:0] = src_level;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      prdata    <= 32'h00000000;
      rd_snap_q <= 14'h0000;
    end else if (setup_ph & ~pwrite) begin
      prdata    <= rdata_d;
      rd_snap_q <= hit_status ? status_q : 14'h0000;
    end
  end

  // ----------------------------------------------------------------
  // interrupt entry
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      pc_push_valid <= 1'b0;
      pc_push_value <= 16'h0000;
      jump_valid    <= 1'b0;
      jump_addr     <= 16'h0000;
    end else begin
      pc_push_valid <= irq_taken & fifo_wave_shared_irq;
      jump_valid    <= irq_taken & fifo_wave_shared_irq;
      if (irq_taken & fifo_wave_shared_irq) begin
        pc_push_value <= return_pc;
        jump_addr     <= `FWAV_ISR_ADDR;
      end
    end
  end

  // ----------------------------------------------------------------
  // code byte substitution
  // ----------------------------------------------------------------
  wire substitute;

  assign substitute = aven_q & win_valid & (code_addr == `FWAV_VEC_ADDR);

  always @(posedge sys_clk) begin
    if (reset) begin
      code_byte_valid <= 1'b0;
      code_byte       <= 8'h00;
    end else begin
      code_byte_valid <= code_fetch;
      if (code_fetch) begin
        code_byte <= substitute ? win_code : code_mem_byte;
      end
    end
  end

endmodule

/* sim/fwav_autovector_properties.sv */
// assertion checker of the fifo/waveform autovector block
module fwav_checker (
  input logic        sys_clk,
  input logic        reset,
  input logic        fifo_wave_shared_irq,
  input logic        irq_taken,
  input logic [15:0] return_pc,
  input logic        pc_push_valid,
  input logic [15:0] pc_push_value,
  input logic        jump_valid,
  input logic [15:0] jump_addr,
  input logic        code_fetch,
  input logic [15:0] code_addr,
  input logic [7:0]  code_mem_byte,
  input logic        code_byte_valid,
  input logic [7:0]  code_byte
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_take;
    irq_taken && fifo_wave_shared_irq |=> pc_push_valid && jump_valid && jump_addr == 16'h0053
      && pc_push_value == $past(return_pc);
  endproperty
  a_take: assert property (p_take) else $error("core entry wrong");
  property p_idle;
    !(irq_taken && fifo_wave_shared_irq) |=> !pc_push_valid && !jump_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("spurious core entry");
  property p_push_hold;
    !(irq_taken && fifo_wave_shared_irq) |=> $stable(pc_push_value);
  endproperty
  a_push_hold: assert property (p_push_hold) else $error("pushed pc moved");
  property p_fetch;
    code_fetch |=> code_byte_valid;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not answered");
  property p_no_fetch;
    !code_fetch |=> !code_byte_valid && $stable(code_byte);
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("code byte without fetch");
  property p_pass;
    code_fetch && (code_addr != 16'h0055 || !fifo_wave_shared_irq) |=> code_byte == $past(code_mem_byte);
  endproperty
  a_pass: assert property (p_pass) else $error("code byte altered");
  property p_code;
    code_fetch && code_addr == 16'h0055 && fifo_wave_shared_irq |=> code_byte == $past(code_mem_byte)
      || (code_byte >= 8'h80 && code_byte <= 8'hb4 && code_byte[1:0] == 2'b00);
  endproperty
  a_code: assert property (p_code) else $error("bad vector code");
  property p_irq_push;
    pc_push_valid |-> jump_valid ##1 !pc_push_valid;
  endproperty
  a_irq_push: assert property (p_irq_push) else $error("entry pulse wrong");
  c_take: cover property (irq_taken && fifo_wave_shared_irq);
  c_sub: cover property (code_fetch && code_addr == 16'h0055 && fifo_wave_shared_irq);
  c_pass: cover property (code_fetch && code_addr == 16'h0054);
endmodule

bind fwav_autovector fwav_checker fwav_checker_i (.sys_clk, .reset, .fifo_wave_shared_irq, .irq_taken,
  .return_pc, .pc_push_valid, .pc_push_value, .jump_valid, .jump_addr, .code_fetch, .code_addr,
  .code_mem_byte, .code_byte_valid, .code_byte);

/* sim/fwav_core_model.sv */
// core and code memory model facing the autovector block
module fwav_core_model #(parameter logic [7:0] PAGE = 8'h12) (
  input  logic        sys_clk,
  input  logic        reset,
  input  logic        irq,
  input  logic        take_en,
  input  logic [15:0] code_addr,
  output logic        irq_taken,
  output logic [15:0] return_pc,
  output logic [7:0]  code_mem_byte
);
  logic done_q;
  assign return_pc = 16'h1234;
  // ----------------------------------------------------------------
  // jump opcode, table page, filler elsewhere
  // ----------------------------------------------------------------
  always_comb begin
    case (code_addr)
      16'h0053: code_mem_byte = 8'h02;
      16'h0054: code_mem_byte = PAGE;
      default:  code_mem_byte = ~code_addr[7:0];
    endcase
  end
  // one take per interrupt episode
  always @(posedge sys_clk) begin
    irq_taken <= !reset && take_en && irq && !done_q && !irq_taken;
    done_q <= !reset && irq && (done_q || irq_taken);
  end
endmodule

/* sim/test_fwav_autovector.sv */
// self-checking bench of the fifo/waveform autovector block
`include "fwav_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_fwav_autovector;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, code_fetch = 0, take_en = 0;
  logic        pready, pslverr, irq, irq_taken, code_byte_valid, pc_push_valid, jump_valid, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [15:0] code_addr = 0, return_pc, pc_push_value, jump_addr;
  logic [13:0] src = 0;
  logic [7:0]  code_mem_byte, code_byte;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  fwav_autovector fwav_autovector_i (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .ep_two_level_flag(src[0]), .ep_four_level_flag(src[1]), .ep_six_level_flag(src[2]),
    .ep_eight_level_flag(src[3]), .ep_two_empty_flag(src[4]), .ep_four_empty_flag(src[5]),
    .ep_six_empty_flag(src[6]), .ep_eight_empty_flag(src[7]), .ep_two_full_flag(src[8]),
    .ep_four_full_flag(src[9]), .ep_six_full_flag(src[10]), .ep_eight_full_flag(src[11]),
    .waveform_engine_done(src[12]), .waveform_engine_wave_event(src[13]), .fifo_wave_shared_irq(irq),
    .irq_taken, .return_pc, .pc_push_valid, .pc_push_value, .jump_valid, .jump_addr, .code_fetch,
    .code_addr, .code_mem_byte, .code_byte_valid, .code_byte);
  fwav_core_model fwav_core_model_i (.sys_clk, .reset, .irq, .take_en, .code_addr, .irq_taken, .return_pc,
    .code_mem_byte);
  // ----------------------------------------------------------------
  // clock, timeout, tasks
  // ----------------------------------------------------------------
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task apb(input logic w, input logic [31:0] a, d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task rdchk(input logic [31:0] a, e);
    apb(0, a, 0);
    `CHK({er, rd}, {1'b0, e})
  endtask
  task fetch(input logic [15:0] a, input logic [7:0] e);
    {code_fetch, code_addr} <= {1'b1, a};
    @(posedge sys_clk);
    code_fetch <= 0;
    @(negedge sys_clk);
    `CHK({code_byte_valid, code_byte}, {1'b1, e})
    @(posedge sys_clk);
  endtask
  task report_and_stop();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    rdchk(`FWAV_OFF_SETUP, 0);
    rdchk(`FWAV_OFF_MASK, 0);
    apb(0, 32'h20, 0);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1, `FWAV_OFF_MASK, 32'h3fff);
    apb(1, `FWAV_OFF_SETUP, 1);
    $display("registers done");
    for (int i = 13; i >= 0; i--) begin
      src[i] <= 1;
      repeat (2) @(posedge sys_clk);
      fetch(16'h0055, 8'h80 + 8'(4 * i));
      rdchk(`FWAV_OFF_VECTOR, 32'h180 + 32'(4 * i));
    end
    `CHK(irq, 1'b1)
    take_en <= 1;
    repeat (4) @(posedge sys_clk);
    `CHK({jump_addr, pc_push_value}, 32'h0053_1234)
    take_en <= 0;
    fetch(16'h0054, 8'h12);
    rdchk(`FWAV_OFF_STATUS, 32'h3fff);
    `CHK(irq, 1'b0)
    fetch(16'h0055, 8'haa);
    $display("vectoring done");
    apb(1, `FWAV_OFF_SETUP, 0);
    src <= 0;
    @(posedge sys_clk);
    src[0] <= 1;
    repeat (2) @(posedge sys_clk);
    fetch(16'h0055, 8'haa);
    `CHK(irq, 1'b1)
    apb(1, `FWAV_OFF_MASK, 0);
    `CHK(irq, 1'b0)
    rdchk(`FWAV_OFF_STATUS, 1);
    $display("disable and mask done");
    report_and_stop();
  end
endmodule
